// ---- shared/rqf_pkg.sv ----
// constants and types shared by the receive queue block and its buffer
// assumes a 32-bit AHB-Lite register window decoded on the low 8 bits
package rqf_pkg;

	// ********************************************************
	// register offsets (byte addresses within the window)
	// ********************************************************
	localparam logic [7:0] OFF_FILTER_ENABLE = 8'hE0;
	localparam logic [7:0] OFF_STATUS = 8'hE8;
	localparam logic [7:0] OFF_CONTROL = 8'hF0;
	localparam logic [7:0] OFF_HEAD = 8'hF4;
	localparam logic [7:0] OFF_SLOT = 8'hF8;

	// ********************************************************
	// field layout
	// ********************************************************
	localparam int FILTER_PAIRS = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int MSG_W = 32;
	localparam int RI_W = 5;
	localparam int FILL_W = 6;
	localparam int STAT_FILL_LSB = 8;
	localparam int STAT_IRI_BIT = 7;
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_SOFT_RST_BIT = 1;
	localparam int CTL_MAILBOX_BIT = 2;

	// ********************************************************
	// reset values and slot addressing
	// ********************************************************
	localparam logic [31:0] FILTER_ENABLE_RST = 32'h0000_0000;
	localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [2:0] SIZE_RST = 3'h0;
	localparam logic CONTROL_BIT_RST = 1'b0;
	localparam logic [15:0] SLOT_BASE = 16'h1100;
	localparam logic [15:0] SLOT_STRIDE = 16'h0048;

	// ********************************************************
	// bus encodings and bus-slave states
	// ********************************************************
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RWAIT = 2'b01,
		ST_RDONE = 2'b11,
		ST_WDATA = 2'b10
	} rqf_bus_state_t;

endpackage

// ---- rtl/rqf_fifo.sv ----
// message buffer of the sequential receive queue, width and depth set
// by parameters; assumes DEPTH is a power of two so pointers wrap freely
`timescale 1ns/1ps
module rqf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count,
	output logic [$clog2(DEPTH)-1:0] rd_index
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_rd;
	logic [CW-1:0] next_count;
	wire push = in_valid & in_ready;
	// a pop on an empty queue is dropped here
	wire pop = out_ready & out_valid;
	wire bypass = push & (wr_ptr == next_rd);

	assign in_ready = (count != FULL_COUNT);
	assign out_valid = (count != '0);
	assign rd_index = rd_ptr;
	assign next_rd = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;

	// ********************************************************
	// occupancy
	// ********************************************************
	// push and pop together leave the count alone
	always_comb
	begin
		next_count = count;
		if (push & ~pop)
			next_count = CW'(count + 1'b1);
		else if (pop & ~push)
			next_count = CW'(count - 1'b1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_data <= '0;
		end
		else if (ce)
		begin
			if (clear)
			begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				count <= '0;
				out_data <= '0;
			end
			else
			begin
				if (push)
					wr_ptr <= AW'(wr_ptr + 1'b1);
				rd_ptr <= next_rd;
				count <= next_count;
				// write-through keeps the head word fresh when empty
				out_data <= bypass ? in_data : mem[next_rd];
			end
		end
	end

	// ********************************************************
	// storage
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (ce & push & ~clear)
			mem[wr_ptr] <= in_data;
	end

endmodule

// ---- rtl/rqf_top.sv ----
// receive queue control: filter pair enables, queue status with read
// index and fill level, host retire strobe, AHB-Lite register slave
// assumes one clock, synchronous inputs and a receive engine that offers
// one finished message per handshake together with its per-pair matches
//
// Contract
// - pair 0 enable bit set makes pair 0 take part in acceptance.
// - enable bits 1 to 9 act alike per pair, read/write, reset zero.
// - in mailbox mode both registers ignore writes and read zero.
// - status bits 13:8 report messages held, 0 to 32, from read index.
// - clearing controller enable keeps fill level and read index.
// - soft or hard reset forces fill level and read index to zero.
// - host writes 1 to bit 7; index advances, fill level drops by one.
// - retire strobe with fill level zero changes nothing.
// - retire together with a stored message leaves fill level unchanged; at fill level zero the code raises it to one.
// - retire strobe bit always reads zero.
// - status bits 4:0 give read index 0 to 31 of next message.
// - index 0 maps to 0x1100, 1 to 0x1148, 31 to 0x19B8.
// - with all enable bits zero no message is stored.
// - enable dropped during reception may store or discard message.
`timescale 1ns/1ps
module rqf_top (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic RX_VALID,
	input wire logic [31:0] RX_DATA,
	input wire logic [31:0] RX_HIT,
	output logic RX_READY,
	output logic [31:0] FILTER_USE
);

	// ********************************************************
	// declarations
	// ********************************************************
	rqf_pkg::rqf_bus_state_t state;
	rqf_pkg::rqf_bus_state_t next_state;
	logic [7:0] a_addr;
	logic a_size_ok;
	logic [31:0] filter_pair_enable;
	logic controller_enable;
	logic soft_reset;
	logic mailbox_mode;
	logic [rqf_pkg::FILTER_PAIRS-1:0] pair_hit;
	logic [rqf_pkg::FILL_W-1:0] fill_level;
	logic [rqf_pkg::RI_W-1:0] read_index;
	logic [rqf_pkg::MSG_W-1:0] head_word;
	logic head_valid;
	logic fifo_in_ready;
	logic [15:0] slot_address;
	logic [31:0] status_word;
	logic [31:0] control_word;
	logic [31:0] rd_word;

	// ********************************************************
	// address phase decode
	// ********************************************************
	wire addr_phase = HSEL & HTRANS[1] & HREADY;
	wire in_rwait = (state == rqf_pkg::ST_RWAIT);
	wire in_wdata = (state == rqf_pkg::ST_WDATA);
	wire fifo_mode = ~mailbox_mode;

	wire sel_filter = (a_addr == rqf_pkg::OFF_FILTER_ENABLE);
	wire sel_status = (a_addr == rqf_pkg::OFF_STATUS);
	wire sel_control = (a_addr == rqf_pkg::OFF_CONTROL);
	wire sel_head = (a_addr == rqf_pkg::OFF_HEAD);
	wire sel_slot = (a_addr == rqf_pkg::OFF_SLOT);

	// writes land at the edge that closes their data phase
	wire wr_fire = CE & in_wdata & a_size_ok;
	wire wr_filter = wr_fire & sel_filter & fifo_mode;
	wire wr_status = wr_fire & sel_status & fifo_mode;
	wire wr_control = wr_fire & sel_control;

	// only bit 7 of a status write does anything
	wire retire = wr_status & HWDATA[rqf_pkg::STAT_IRI_BIT];

	// ********************************************************
	// bus handshake
	// ********************************************************
	// one wait state on reads so a read right behind a write sees it;
	// a low clock enable stretches every data phase
	assign HREADYOUT = CE & ~in_rwait;
	assign HRESP = rqf_pkg::HRESP_OKAY;

	always_comb
	begin
		next_state = state;
		case (state)
			rqf_pkg::ST_RWAIT:
				next_state = rqf_pkg::ST_RDONE;
			rqf_pkg::ST_IDLE,
			rqf_pkg::ST_RDONE,
			rqf_pkg::ST_WDATA:
			begin
				if (addr_phase & HWRITE)
					next_state = rqf_pkg::ST_WDATA;
				else if (addr_phase)
					next_state = rqf_pkg::ST_RWAIT;
				else
					next_state = rqf_pkg::ST_IDLE;
			end
			default:
				next_state = rqf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			state <= rqf_pkg::ST_IDLE;
		else if (CE)
			state <= next_state;
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			a_addr <= rqf_pkg::ADDR_RST;
			a_size_ok <= 1'b0;
		end
		else if (CE & addr_phase & ~in_rwait)
		begin
			a_addr <= HADDR;
			a_size_ok <= (HSIZE == rqf_pkg::SIZE_WORD);
		end
	end

	// ********************************************************
	// filter pair enables
	// ********************************************************
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			filter_pair_enable <= rqf_pkg::FILTER_ENABLE_RST;
		else if (wr_filter)
			filter_pair_enable <= HWDATA;
	end

	// the comparators see no pair at all while mailbox mode is set
	assign FILTER_USE = mailbox_mode ? '0 : filter_pair_enable;

	// a message passes when any enabled pair matched it
	genvar p;
	generate
		for (p = 0; p < rqf_pkg::FILTER_PAIRS; p++)
		begin : g_pair
			assign pair_hit[p] = RX_HIT[p] & filter_pair_enable[p];
		end
	endgenerate

	// enables are sampled at the handshake, so a bit dropped mid-frame
	// decides by its value at the edge where the frame is taken
	wire accepted = |pair_hit;

	// ********************************************************
	// control: enable, soft reset pulse, buffer mode
	// ********************************************************
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			controller_enable <= rqf_pkg::CONTROL_BIT_RST;
			soft_reset <= rqf_pkg::CONTROL_BIT_RST;
			mailbox_mode <= rqf_pkg::CONTROL_BIT_RST;
		end
		else if (CE)
		begin
			soft_reset <= wr_control & HWDATA[rqf_pkg::CTL_SOFT_RST_BIT];
			if (wr_control)
			begin
				// dropping the enable leaves the queue pointers alone
				controller_enable <= HWDATA[rqf_pkg::CTL_ENABLE_BIT];
				mailbox_mode <= HWDATA[rqf_pkg::CTL_MAILBOX_BIT];
			end
		end
	end

	// ********************************************************
	// receive path into the queue
	// ********************************************************
	// rejected messages are consumed and dropped; accepted ones wait
	// for room, which is how a full queue stalls the receive engine
	wire rx_open = controller_enable & fifo_mode;
	assign RX_READY = rx_open & (fifo_in_ready | ~accepted);
	wire rx_store = RX_VALID & rx_open & accepted;

	rqf_fifo #(
		.WIDTH(rqf_pkg::MSG_W),
		.DEPTH(rqf_pkg::FIFO_DEPTH)
	) u_queue (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.clear(soft_reset),
		.in_valid(rx_store),
		.in_ready(fifo_in_ready),
		.in_data(RX_DATA),
		.out_valid(head_valid),
		.out_ready(retire),
		.out_data(head_word),
		.count(fill_level),
		.rd_index(read_index)
	);

	// ********************************************************
	// read data
	// ********************************************************
	// fill level needs six bits to reach 32, so its top bit takes 13
	assign status_word = {
		18'h0_0000,
		fill_level,
		1'b0,
		2'h0,
		read_index
	};

	assign slot_address = 16'(rqf_pkg::SLOT_BASE +
		16'(16'(read_index) * rqf_pkg::SLOT_STRIDE));

	assign control_word = {
		29'h0000_0000,
		mailbox_mode,
		1'b0,
		controller_enable
	};

	wire [31:0] filter_rd = fifo_mode ? filter_pair_enable : '0;
	wire [31:0] status_rd = fifo_mode ? status_word : '0;
	wire [31:0] head_rd = (fifo_mode & head_valid) ? head_word : '0;
	wire [31:0] slot_rd = fifo_mode ? {16'h0000, slot_address} : '0;

	// unmapped offsets read as zero
	assign rd_word = ({32{sel_filter}} & filter_rd)
		| ({32{sel_status}} & status_rd)
		| ({32{sel_control}} & control_word)
		| ({32{sel_head}} & head_rd)
		| ({32{sel_slot}} & slot_rd);

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			HRDATA <= rqf_pkg::HRDATA_RST;
		else if (CE & in_rwait)
			HRDATA <= rd_word;
	end

endmodule

// ---- sim/rqf_rx_model.sv ----
// receive engine stand-in offering queued messages one at a time
// assumes a word is taken where valid and ready meet at a rising edge
`timescale 1ns/1ps
module rqf_rx_model (
	input wire logic clk,
	input wire logic ready,
	output logic valid,
	output logic [31:0] data,
	output logic [31:0] hit
);
	logic [63:0] q[$];
	logic slow = 1'b0;
	logic took;
	initial
	begin
		valid = 1'b0;
		data = 32'h0;
		hit = 32'h0;
	end
	task automatic push(input logic [31:0] d, input logic [31:0] h);
		q.push_back({h, d});
	endtask
	function automatic logic idle();
		return q.size() == 0 && !valid;
	endfunction
	// offer held until taken; idle lines toggle so no stale word lingers
	always @(posedge clk)
	begin
		took = valid && ready;
		if (took)
			void'(q.pop_front());
		if (q.size() != 0 && !(slow && took))
		begin
			valid <= 1'b1;
			{hit, data} <= q[0];
		end
		else
		begin
			valid <= 1'b0;
			data <= ~data;
			hit <= ~hit;
		end
	end
endmodule

// ---- sim/rqf_top_props.sv ----
// checker of the receive queue block on its top ports
// assumes one slave, so HREADY is the block's own HREADYOUT
`timescale 1ns/1ps
module rqf_top_props (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic RX_READY,
	input wire logic [31:0] FILTER_USE
);
	// ****************************************
	// bus phase tracking
	// ****************************************
	logic tk, ph_wr, ph_rd, mbox;
	logic [7:0] ph_a;
	assign tk = HSEL & HTRANS[1] & HREADY & CE;
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_a <= 8'h00;
			mbox <= 1'b0;
		end
		else if (CE)
		begin
			ph_wr <= tk & HWRITE & (HSIZE == 3'h2);
			ph_rd <= tk ? !HWRITE : ph_rd & !HREADYOUT;
			if (tk)
				ph_a <= HADDR;
			if (ph_wr && ph_a == 8'hF0)
				mbox <= HWDATA[2];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	sequence s_rd_answer;
		!HREADYOUT ##1 HREADYOUT;
	endsequence
	property p_resp_okay;
		HRESP == 1'b0;
	endproperty
	property p_rd_timing;
		tk && !HWRITE |=> s_rd_answer;
	endproperty
	property p_wr_timing;
		tk && HWRITE |=> HREADYOUT;
	endproperty
	property p_fe_write;
		ph_wr && ph_a == 8'hE0 && !mbox |=> FILTER_USE == $past(HWDATA);
	endproperty
	property p_fe_hold;
		!(ph_wr && (ph_a == 8'hE0 || ph_a == 8'hF0)) |=> $stable(FILTER_USE);
	endproperty
	property p_mbox_fe;
		mbox && $past(mbox) |-> FILTER_USE == 32'h0;
	endproperty
	property p_mbox_rd;
		ph_rd && HREADYOUT && mbox && (ph_a == 8'hE0 || ph_a == 8'hE8)
			|-> HRDATA == 32'h0;
	endproperty
	property p_stat_rsvd;
		ph_rd && HREADYOUT && ph_a == 8'hE8 |-> HRDATA[31:14] == 18'h0
			&& HRDATA[7:5] == 3'h0 && HRDATA[13:8] <= 6'h20;
	endproperty
	property p_mbox_rx;
		mbox |-> !RX_READY;
	endproperty
	a_resp_okay: assert property (p_resp_okay)
		else $error("bus response not okay");
	a_rd_timing: assert property (p_rd_timing)
		else $error("read answer not after one wait cycle");
	a_wr_timing: assert property (p_wr_timing)
		else $error("write data phase stalled");
	a_fe_write: assert property (p_fe_write)
		else $error("pair enables differ from written word");
	a_fe_hold: assert property (p_fe_hold)
		else $error("pair enables changed without a write");
	a_mbox_fe: assert property (p_mbox_fe)
		else $error("pair enables live in mailbox mode");
	a_mbox_rd: assert property (p_mbox_rd)
		else $error("queue register nonzero in mailbox mode");
	a_stat_rsvd: assert property (p_stat_rsvd)
		else $error("status reserved or strobe bits set");
	a_mbox_rx: assert property (p_mbox_rx)
		else $error("receive stream open in mailbox mode");
endmodule
bind rqf_top rqf_top_props u_props (.CLOCK(CLOCK), .RST(RST), .CE(CE),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_READY(RX_READY),
	.FILTER_USE(FILTER_USE));

// ---- sim/tb_rx_fifo_read_index_and_filter_enable.sv ----
// bench for the receive queue: AHB-Lite register calls and messages
// assumes the receive engine stand-in drives the stream side
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		tests_run++; \
		if ((a) !== (b)) \
		begin \
			err_count++; \
			$display("wrong value at %0t: %h vs %h", $time, a, b); \
		end \
	end
module tb_rx_fifo_read_index_and_filter_enable;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b0;
	logic [7:0] HADDR = 8'h00;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA, RX_DATA, RX_HIT, FILTER_USE, rd;
	logic HREADYOUT, HRESP, RX_VALID, RX_READY;
	int err_count = 0;
	int tests_run = 0;
	logic [5:0] fill = 6'h0;
	logic [4:0] idx = 5'h0;
	logic [31:0] en = 32'h0;
	always #50 CLOCK = ~CLOCK;
	rqf_top u_dut (.CLOCK(CLOCK), .RST(RST), .CE(1'b1), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA), .RX_HIT(RX_HIT), .RX_READY(RX_READY),
		.FILTER_USE(FILTER_USE));
	rqf_rx_model u_rx (.clk(CLOCK), .ready(RX_READY), .valid(RX_VALID),
		.data(RX_DATA), .hit(RX_HIT));
	// ****************************************
	// tasks
	// ****************************************
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// returns right after the rising edge at which ready is sampled high
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge CLOCK);
		while (HREADYOUT !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				err_count++;
				conclude();
			end
			@(posedge CLOCK);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		wait_rdy();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		// read data taken at the same edge that samples ready high
		rd = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic st();
		xfer(1'b0, 8'hE8, 32'h0);
		`CHK(rd, {18'h0, fill, 3'h0, idx})
		xfer(1'b0, 8'hF8, 32'h0);
		`CHK(rd[15:0], 16'h1100 + 16'h0048 * idx)
	endtask
	// strobe written with reserved and read-only bits set as well
	task automatic ret();
		wr(8'hE8, 32'hFFFF_FF80);
		if (fill != 6'h0)
		begin
			fill--;
			idx++;
		end
	endtask
	task automatic drain();
		int n;
		n = 0;
		@(posedge CLOCK);
		while (!u_rx.idle())
		begin
			n++;
			if (n > 99)
			begin
				err_count++;
				conclude();
			end
			@(posedge CLOCK);
		end
	endtask
	task automatic rx(input logic [31:0] h);
		u_rx.push(32'hC0DE_0000 ^ h, h);
		drain();
		if ((h & en) != 32'h0)
			fill++;
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		rchk(8'hE0, 32'h0);
		st();
		wr(8'hE0, 32'hA5A5_03FF);
		rchk(8'hE0, 32'hA5A5_03FF);
		`CHK(FILTER_USE, 32'hA5A5_03FF)
		// a byte-sized write must leave the enables alone
		HSIZE <= 3'h0;
		wr(8'hE0, 32'h0);
		HSIZE <= 3'h2;
		rchk(8'hE0, 32'hA5A5_03FF);
		wr(8'h10, 32'hFFFF_FFFF);
		rchk(8'h10, 32'h0);
		wr(8'hE0, 32'h0);
		en = 32'h0;
		wr(8'hF0, 32'h1);
		rx(32'hFFFF_FFFF);
		st();
		wr(8'hE0, 32'h1);
		en = 32'h1;
		rx(32'h1);
		rx(32'h2);
		rx(32'h8000_0001);
		rx(32'h1);
		st();
		rchk(8'hF4, 32'hC0DE_0001);
		ret();
		st();
		wr(8'hF0, 32'h0);
		st();
		ret();
		ret();
		ret();
		st();
		wr(8'hF0, 32'h1);
		u_rx.slow = 1'b1;
		repeat (32) rx(32'h1);
		st();
		u_rx.push(32'h1234_5678, 32'h1);
		repeat (3) @(posedge CLOCK);
		`CHK(RX_READY, 1'b0)
		ret();
		drain();
		fill++;
		st();
		repeat (32)
		begin
			ret();
			st();
		end
		rx(32'h1);
		rx(32'h1);
		wr(8'hF0, 32'h3);
		fill = 6'h0;
		idx = 5'h0;
		st();
		rx(32'h1);
		wr(8'hF0, 32'h5);
		wr(8'hE0, 32'hFF);
		wr(8'hE8, 32'h80);
		rchk(8'hE0, 32'h0);
		rchk(8'hE8, 32'h0);
		`CHK(FILTER_USE, 32'h0)
		wr(8'hF0, 32'h1);
		rchk(8'hE0, 32'h1);
		st();
		RST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		fill = 6'h0;
		st();
		rchk(8'hE0, 32'h0);
		conclude();
	end
endmodule
